// ===== src/io_bridge_pkg.sv
// Shared constants, encodings and carriers of the I/O coherence bridge
package io_bridge_pkg;

  // ----------------------------------------------------------------
  // Widths and geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 40;
  localparam int BEAT_W      = 128;
  localparam int BEAT_SHIFT  = 4;             // 16 bytes per beat
  localparam int MAX_BEATS   = 16;            // 256-byte burst ceiling
  localparam int LEN_W       = 4;             // Beats minus one
  localparam int IDX_W       = 5;
  localparam int TAG_W       = 4;
  localparam int LINE_BEATS  = 2;
  localparam int SLOT_W      = 1;
  localparam int LINE_W      = LINE_BEATS * BEAT_W;
  localparam int MST_ADDR_W  = 32;
  localparam int MST_DATA_W  = 32;
  localparam int RATIO_W     = 4;

  // ----------------------------------------------------------------
  // Reset values and ratio settings
  // ----------------------------------------------------------------
  localparam logic [RATIO_W-1:0] RATIO_RESET = 4'h1;
  localparam logic [RATIO_W-1:0] RATIO_MAX   = 4'ha;
  localparam logic [IDX_W-1:0]   IDX_RESET   = 5'h00;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ATTR_COHERENT   = 2'h0,
    ATTR_NONCOH_L2  = 2'h1,
    ATTR_UNCACHED   = 2'h2,
    ATTR_SPARE      = 2'h3
  } attr_e;

  typedef enum logic [1:0] {
    ROUTE_L1_L2  = 2'h0,
    ROUTE_L2     = 2'h1,
    ROUTE_MEMORY = 2'h2,
    ROUTE_NONE   = 2'h3
  } route_e;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              write;
    attr_e             attr;
    logic [ADDR_W-1:0] addr;
    logic [LEN_W-1:0]  len;
    logic [TAG_W-1:0]  tag;
    logic              resp_req;
  } io_req_s;

  typedef struct packed {
    logic [BEAT_W-1:0] data;
    logic [TAG_W-1:0]  tag;
    logic              last;
  } io_rbeat_s;

  typedef struct packed {
    logic                  write;
    route_e                route;
    logic [ADDR_W-1:0]     addr;
    logic [LINE_W-1:0]     data;
    logic [LINE_BEATS-1:0] mask;
  } cm_req_s;

  typedef struct packed {
    logic                  write;
    logic [MST_ADDR_W-1:0] addr;
    logic [MST_DATA_W-1:0] data;
  } mst_req_s;

endpackage

// ===== src/io_ratio_enable.sv
// Divider that makes the I/O side enable pulse at a strapped ratio
`timescale 1ns/10ps
module io_ratio_enable (
  // Clock and reset
  input  wire logic                             sys_clk,
  input  wire logic                             rst,
  // Ratio strap, divisor value 1,2,3,4,5 or 10
  input  wire logic [io_bridge_pkg::RATIO_W-1:0] ratio,
  // One-cycle I/O side enable
  output logic                                  io_ce
);

  logic [io_bridge_pkg::RATIO_W-1:0] ratio_meta;
  logic [io_bridge_pkg::RATIO_W-1:0] ratio_sync;
  logic [io_bridge_pkg::RATIO_W-1:0] count;
  logic [io_bridge_pkg::RATIO_W-1:0] next_count;
  logic [io_bridge_pkg::RATIO_W-1:0] divisor;
  logic                              next_io_ce;

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ratio_meta <= io_bridge_pkg::RATIO_RESET;
      ratio_sync <= io_bridge_pkg::RATIO_RESET;
    end else begin
      ratio_meta <= ratio;
      ratio_sync <= ratio_meta;
    end
  end

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // ratio set
  always_comb begin
    unique case (ratio_sync)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'ha: divisor = ratio_sync;
      default:                              divisor = io_bridge_pkg::RATIO_RESET;
    endcase
    if (count + 4'h1 >= divisor) begin
      next_count = '0;
      next_io_ce = 1'b1;
    end else begin
      next_count = count + 4'h1;
      next_io_ce = 1'b0;
    end
  end

  // Divider registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      io_ce <= 1'b0;
    end else begin
      count <= next_count;
      io_ce <= next_io_ce;
    end
  end

endmodule // io_ratio_enable

// ===== src/burst_beat_store.sv
// Flip-flop store for the beats of one write burst
`timescale 1ns/10ps
module burst_beat_store #(
  parameter int WIDTH = 128,
  parameter int DEPTH = 16
) (
  // Clock
  input  wire logic                          sys_clk,
  // Write port
  input  wire logic                          wr_en,
  input  wire logic [$clog2(DEPTH)-1:0]      wr_idx,
  input  wire logic [WIDTH-1:0]              wr_data,
  // Whole contents, read by index
  output logic      [DEPTH-1:0][WIDTH-1:0]   contents
);

  logic [DEPTH-1:0][WIDTH-1:0] next_contents;

  // ----------------------------------------------------------------
  // Entries
  // ----------------------------------------------------------------
  for (genvar e = 0; e < DEPTH; e++) begin : g_entry
    // Load one entry when addressed
    always_comb begin
      next_contents[e] = contents[e];
      if (wr_en && (int'(wr_idx) == e)) begin
        next_contents[e] = wr_data;
      end
    end

    // Entry register
    always_ff @(posedge sys_clk) begin
      contents[e] <= next_contents[e];
    end
  end

endmodule // burst_beat_store

// ===== src/io_coherence_bridge.sv
// I/O coherence bridge: I/O slave to coherence manager, CPU to I/O master
`timescale 1ns/10ps
module io_coherence_bridge (
  // Clock and reset
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst,
  // I/O side ratio strap
  input  wire logic [io_bridge_pkg::RATIO_W-1:0]       io_ratio,
  // I/O slave request
  input  wire logic                                    io_req_valid,
  input  wire io_bridge_pkg::io_req_s                  io_req,
  output logic                                         io_req_ready,
  // I/O slave write data
  input  wire logic                                    io_wvalid,
  input  wire logic [io_bridge_pkg::BEAT_W-1:0]        io_wdata,
  output logic                                         io_wready,
  // I/O slave read data and write response
  output logic                                         io_rvalid,
  output io_bridge_pkg::io_rbeat_s                     io_rbeat,
  output logic                                         io_bvalid,
  output logic [io_bridge_pkg::TAG_W-1:0]              io_btag,
  // Coherence manager request
  output logic                                         cm_req_valid,
  output io_bridge_pkg::cm_req_s                       cm_req,
  input  wire logic                                    cm_req_ready,
  // Coherence manager answers
  input  wire logic                                    cm_rvalid,
  input  wire logic [io_bridge_pkg::LINE_W-1:0]        cm_rdata,
  input  wire logic                                    cm_wack,
  // CPU access toward I/O devices
  input  wire logic                                    cpu_req_valid,
  input  wire io_bridge_pkg::mst_req_s                 cpu_req,
  output logic                                         cpu_req_ready,
  output logic                                         cpu_rsp_valid,
  output logic [io_bridge_pkg::MST_DATA_W-1:0]         cpu_rsp_data,
  // I/O master port
  output logic                                         mst_valid,
  output io_bridge_pkg::mst_req_s                      mst_req,
  input  wire logic                                    mst_ready,
  input  wire logic                                    mst_rsp_valid,
  input  wire logic [io_bridge_pkg::MST_DATA_W-1:0]    mst_rsp_data
);

  localparam int BW = io_bridge_pkg::BEAT_W;
  localparam int LB = io_bridge_pkg::LINE_BEATS;

  typedef enum logic [6:0] {
    S_IDLE  = 7'h01,
    S_WDATA = 7'h02,
    S_ISSUE = 7'h04,
    S_RWAIT = 7'h08,
    S_RRESP = 7'h10,
    S_ACK   = 7'h20,
    S_BRESP = 7'h40
  } slave_state_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_SEND = 3'h2,
    M_WAIT = 3'h4
  } master_state_e;

  logic io_ce;

  // Slave side state
  slave_state_e                                state, next_state;
  io_bridge_pkg::io_req_s                      cur, next_cur;
  logic [io_bridge_pkg::IDX_W-1:0]             idx, next_idx;
  logic [io_bridge_pkg::IDX_W-1:0]             pending, next_pending;
  logic [io_bridge_pkg::SLOT_W-1:0]            slot, next_slot;
  logic [io_bridge_pkg::IDX_W-1:0]             pbeats, next_pbeats;
  logic [io_bridge_pkg::LINE_W-1:0]            line, next_line;
  logic                                        next_io_req_ready, next_io_wready;
  logic                                        next_io_rvalid, next_io_bvalid;
  io_bridge_pkg::io_rbeat_s                    next_io_rbeat;
  logic [io_bridge_pkg::TAG_W-1:0]             next_io_btag;
  logic                                        next_cm_req_valid;
  io_bridge_pkg::cm_req_s                      next_cm_req;

  // Piece arithmetic
  logic [io_bridge_pkg::ADDR_W-1:0]            beat_addr;
  logic [io_bridge_pkg::SLOT_W-1:0]            slot0;
  logic [io_bridge_pkg::IDX_W-1:0]             remain, room, piece;
  logic [LB-1:0]                               mask;
  logic [io_bridge_pkg::LINE_W-1:0]            pdata;
  io_bridge_pkg::route_e                       route;
  logic                                        wr_en;
  logic [io_bridge_pkg::MAX_BEATS-1:0][BW-1:0] beats;

  // Master side state
  master_state_e                               mstate, next_mstate;
  logic                                        next_cpu_req_ready, next_cpu_rsp_valid;
  logic [io_bridge_pkg::MST_DATA_W-1:0]        next_cpu_rsp_data;
  logic                                        next_mst_valid;
  io_bridge_pkg::mst_req_s                     next_mst_req;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // ratio enable
  io_ratio_enable u_ratio (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ratio   (io_ratio),
    .io_ce   (io_ce)
  );

  // Write burst beats, indexed by beat number
  assign wr_en = (state == S_WDATA) && io_ce && io_wvalid && io_wready;

  burst_beat_store #(
    .WIDTH (BW),
    .DEPTH (io_bridge_pkg::MAX_BEATS)
  ) u_store (
    .sys_clk  (sys_clk),
    .wr_en    (wr_en),
    .wr_idx   (idx[io_bridge_pkg::LEN_W-1:0]),
    .wr_data  (io_wdata),
    .contents (beats)
  );

  // ----------------------------------------------------------------
  // Routing and line pieces
  // ----------------------------------------------------------------
  // attribute routing
  always_comb begin
    unique case (cur.attr)
      io_bridge_pkg::ATTR_COHERENT:  route = io_bridge_pkg::ROUTE_L1_L2;
      io_bridge_pkg::ATTR_NONCOH_L2: route = io_bridge_pkg::ROUTE_L2;
      default:                       route = io_bridge_pkg::ROUTE_MEMORY;
    endcase
  end

  always_comb begin
    beat_addr = cur.addr + {{(io_bridge_pkg::ADDR_W-io_bridge_pkg::IDX_W
                 -io_bridge_pkg::BEAT_SHIFT){1'b0}}, idx, 4'h0};
    slot0     = beat_addr[io_bridge_pkg::BEAT_SHIFT +: io_bridge_pkg::SLOT_W];
    remain    = {1'b0, cur.len} + 5'h01 - idx;
    room      = 5'(LB) - {{(io_bridge_pkg::IDX_W-io_bridge_pkg::SLOT_W){1'b0}}, slot0};
    piece     = (remain < room) ? remain : room;
    mask      = '0;
    pdata     = '0;
    for (int k = 0; k < LB; k++) begin
      if ((5'(k) >= 5'(slot0)) && (5'(k) < 5'(slot0) + piece)) begin
        mask[k] = 1'b1;
        pdata[k*BW +: BW] = beats[4'(idx + 5'(k) - 5'(slot0))];
      end
    end
  end

  // ----------------------------------------------------------------
  // Slave transfer sequencer, next values
  // ----------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_cur          = cur;
    next_idx          = idx;
    next_pending      = pending;
    next_slot         = slot;
    next_pbeats       = pbeats;
    next_line         = line;
    next_io_req_ready = io_req_ready;
    next_io_wready    = io_wready;
    next_io_rvalid    = io_rvalid;
    next_io_rbeat     = io_rbeat;
    next_io_bvalid    = io_bvalid;
    next_io_btag      = io_btag;
    next_cm_req_valid = cm_req_valid;
    next_cm_req       = cm_req;
    if (cm_wack && (pending != '0)) begin
      next_pending = pending - 5'h01;
    end
    // Single-period I/O answers drop at the next enable
    if (io_ce) begin
      next_io_rvalid = 1'b0;
      next_io_bvalid = 1'b0;
    end
    unique case (state)
      S_IDLE: begin
        if (io_ce && io_req_valid && io_req_ready) begin
          next_cur          = io_req;
          next_idx          = io_bridge_pkg::IDX_RESET;
          next_io_req_ready = 1'b0;
          if (io_req.write) begin
            next_io_wready = 1'b1;
            next_state     = S_WDATA;
          end else begin
            next_state     = S_ISSUE;
          end
        end
      end
      S_WDATA: begin
        if (wr_en) begin
          next_idx = idx + 5'h01;
          if (idx[io_bridge_pkg::LEN_W-1:0] == cur.len) begin
            next_io_wready = 1'b0;
            next_idx       = io_bridge_pkg::IDX_RESET;
            next_state     = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (!cm_req_valid) begin
          next_cm_req_valid = 1'b1;
          next_cm_req.write = cur.write;
          next_cm_req.route = route;
          next_cm_req.addr  = {beat_addr[io_bridge_pkg::ADDR_W-1:
                               io_bridge_pkg::BEAT_SHIFT+io_bridge_pkg::SLOT_W],
                               {(io_bridge_pkg::BEAT_SHIFT+io_bridge_pkg::SLOT_W){1'b0}}};
          next_cm_req.data  = pdata;
          next_cm_req.mask  = mask;
          next_slot         = slot0;
          next_pbeats       = piece;
        end else if (cm_req_ready) begin
          next_cm_req_valid = 1'b0;
          if (cur.write) begin
            next_pending = next_pending + 5'h01;
            next_idx     = idx + pbeats;
            if (idx + pbeats > {1'b0, cur.len}) begin
              next_state = S_ACK;
            end
          end else begin
            next_state = S_RWAIT;
          end
        end
      end
      S_RWAIT: begin
        if (cm_rvalid) begin
          next_line  = cm_rdata;
          next_state = S_RRESP;
        end
      end
      S_RRESP: begin
        if (io_ce) begin
          next_io_rvalid     = 1'b1;
          next_io_rbeat.data = line[slot*BW +: BW];
          next_io_rbeat.tag  = cur.tag;
          next_io_rbeat.last = (idx[io_bridge_pkg::LEN_W-1:0] == cur.len);
          next_slot          = slot + 1'b1;
          next_pbeats        = pbeats - 5'h01;
          next_idx           = idx + 5'h01;
          if (idx[io_bridge_pkg::LEN_W-1:0] == cur.len) begin
            next_io_req_ready = 1'b1;
            next_state        = S_IDLE;
          end else if (pbeats == 5'h01) begin
            next_state = S_ISSUE;
          end
        end
      end
      S_ACK: begin
        if (next_pending == '0) begin
          if (cur.resp_req) begin
            next_state = S_BRESP;
          end else begin
            next_io_req_ready = 1'b1;
            next_state        = S_IDLE;
          end
        end
      end
      S_BRESP: begin
        if (io_ce) begin
          next_io_bvalid    = 1'b1;
          next_io_btag      = cur.tag;
          next_io_req_ready = 1'b1;
          next_state        = S_IDLE;
        end
      end
    endcase
  end

  // Slave sequencer registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state        <= S_IDLE;
      cur          <= '0;
      idx          <= io_bridge_pkg::IDX_RESET;
      pending      <= '0;
      slot         <= '0;
      pbeats       <= '0;
      line         <= '0;
      io_req_ready <= 1'b1;
      io_wready    <= 1'b0;
      io_rvalid    <= 1'b0;
      io_rbeat     <= '0;
      io_bvalid    <= 1'b0;
      io_btag      <= '0;
      cm_req_valid <= 1'b0;
      cm_req       <= '0;
    end else begin
      state        <= next_state;
      cur          <= next_cur;
      idx          <= next_idx;
      pending      <= next_pending;
      slot         <= next_slot;
      pbeats       <= next_pbeats;
      line         <= next_line;
      io_req_ready <= next_io_req_ready;
      io_wready    <= next_io_wready;
      io_rvalid    <= next_io_rvalid;
      io_rbeat     <= next_io_rbeat;
      io_bvalid    <= next_io_bvalid;
      io_btag      <= next_io_btag;
      cm_req_valid <= next_cm_req_valid;
      cm_req       <= next_cm_req;
    end
  end

  // ----------------------------------------------------------------
  // CPU to I/O master port, next values
  // ----------------------------------------------------------------
  // forward CPU accesses
  always_comb begin
    next_mstate        = mstate;
    next_cpu_req_ready = cpu_req_ready;
    next_cpu_rsp_valid = 1'b0;
    next_cpu_rsp_data  = cpu_rsp_data;
    next_mst_valid     = mst_valid;
    next_mst_req       = mst_req;
    unique case (mstate)
      M_IDLE: begin
        if (cpu_req_valid && cpu_req_ready) begin
          next_mst_req       = cpu_req;
          next_mst_valid     = 1'b1;
          next_cpu_req_ready = 1'b0;
          next_mstate        = M_SEND;
        end
      end
      M_SEND: begin
        if (io_ce && mst_ready) begin
          next_mst_valid = 1'b0;
          next_mstate    = M_WAIT;
        end
      end
      M_WAIT: begin
        if (io_ce && mst_rsp_valid) begin
          next_cpu_rsp_valid = 1'b1;
          next_cpu_rsp_data  = mst_rsp_data;
          next_cpu_req_ready = 1'b1;
          next_mstate        = M_IDLE;
        end
      end
    endcase
  end

  // Master port registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mstate        <= M_IDLE;
      cpu_req_ready <= 1'b1;
      cpu_rsp_valid <= 1'b0;
      cpu_rsp_data  <= '0;
      mst_valid     <= 1'b0;
      mst_req       <= '0;
    end else begin
      mstate        <= next_mstate;
      cpu_req_ready <= next_cpu_req_ready;
      cpu_rsp_valid <= next_cpu_rsp_valid;
      cpu_rsp_data  <= next_cpu_rsp_data;
      mst_valid     <= next_mst_valid;
      mst_req       <= next_mst_req;
    end
  end

endmodule // io_coherence_bridge

// ===== verification/io_coherence_bridge_chk.sv
// Port checker for the I/O coherence bridge, with its bind
`timescale 1ns/10ps
module io_coherence_bridge_chk (
  // Clock and reset
  input wire logic                     sys_clk,
  input wire logic                     rst,
  // I/O slave side
  input wire io_bridge_pkg::io_req_s   io_req,
  input wire logic                     io_req_ready,
  input wire logic                     io_rvalid,
  input wire io_bridge_pkg::io_rbeat_s io_rbeat,
  input wire logic                     io_bvalid,
  input wire logic [3:0]               io_btag,
  // Manager and master sides
  input wire logic                     cm_req_valid,
  input wire io_bridge_pkg::cm_req_s   cm_req,
  input wire logic                     cm_req_ready,
  input wire logic                     cm_rvalid,
  input wire logic                     mst_valid,
  input wire io_bridge_pkg::mst_req_s  mst_req,
  input wire logic                     mst_ready
);
  io_bridge_pkg::io_req_s lr;
  logic                   ro;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Accepted request and read piece outstanding
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lr <= '0;
      ro <= 1'b0;
    end else begin
      if ($fell(io_req_ready)) begin
        lr <= $past(io_req);
      end
      ro <= (ro && !cm_rvalid) || (cm_req_valid && cm_req_ready && !cm_req.write);
    end
  end
  a_route_coh: assert property (
    cm_req_valid && lr.attr == io_bridge_pkg::ATTR_COHERENT
    |-> cm_req.route == io_bridge_pkg::ROUTE_L1_L2) else $error("coherent route wrong");
  a_route_l2: assert property (
    cm_req_valid && lr.attr == io_bridge_pkg::ATTR_NONCOH_L2
    |-> cm_req.route == io_bridge_pkg::ROUTE_L2) else $error("cached route wrong");
  a_route_mem: assert property (
    cm_req_valid && lr.attr >= io_bridge_pkg::ATTR_UNCACHED
    |-> cm_req.route == io_bridge_pkg::ROUTE_MEMORY) else $error("uncached route wrong");
  a_cm_hold: assert property (
    cm_req_valid && !cm_req_ready |=> cm_req_valid && $stable(cm_req)) else $error("cm req moved");
  a_line_align: assert property (
    cm_req_valid |-> cm_req.addr[4:0] == 5'h00 && cm_req.mask != 2'h0) else $error("bad piece");
  a_read_single: assert property (
    ro |-> !cm_req_valid) else $error("second read piece too early");
  a_rtag_match: assert property (
    io_rvalid |-> io_rbeat.tag == lr.tag && !lr.write) else $error("read tag wrong");
  a_bresp_tag: assert property (
    io_bvalid |-> io_btag == lr.tag && lr.resp_req && lr.write) else $error("write resp wrong");
  a_mst_hold: assert property (
    mst_valid && !mst_ready |=> mst_valid && $stable(mst_req)) else $error("mst req moved");
endmodule // io_coherence_bridge_chk

bind io_coherence_bridge io_coherence_bridge_chk chk (.*);

// ===== verification/cm_partner.sv
// Coherence manager and I/O device model facing the bridge
`timescale 1ns/10ps
module cm_partner (
  // Clock, reset and ratio
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  input  wire logic [3:0]              ratio,
  // Manager side
  input  wire logic                    cm_req_valid,
  input  wire io_bridge_pkg::cm_req_s  cm_req,
  output logic                         cm_req_ready,
  output logic                         cm_rvalid,
  output logic [255:0]                 cm_rdata,
  output logic                         cm_wack,
  // Device side
  input  wire logic                    mst_valid,
  input  wire io_bridge_pkg::mst_req_s mst_req,
  output logic                         mst_ready,
  output logic                         mst_rsp_valid,
  output logic [31:0]                  mst_rsp_data,
  // Counts for the bench
  output int                           pieces,
  output int                           wbad,
  output io_bridge_pkg::mst_req_s      seen
);
  logic [39:0] ra;
  logic [3:0]  rc;
  logic        rd, coh, mv, hs, ak, rv, hold;
  int          acks, nb;
  // Manager: random stall, one read answered late, acks later
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {cm_req_ready, cm_rvalid, cm_wack, rd, coh} <= '0;
      cm_rdata <= '0;
      {acks, pieces, wbad} <= '0;
    end else begin
      hs = cm_req_valid && cm_req_ready;
      cm_req_ready <= 1'($urandom);
      ak = acks > 0 && $urandom_range(coh ? 5 : 1) == 0;
      cm_wack <= ak;
      acks <= acks + int'(hs && cm_req.write) - int'(ak);
      rv = rd && $urandom_range(3) == 0;
      cm_rvalid <= rv;
      cm_rdata <= rv ? {88'h0, ra + 40'h10, 88'h0, ra} : ~cm_rdata;
      if (rv) rd <= 1'b0;
      nb = 0;
      for (int k = 0; k < 2; k++) begin
        if (cm_req.mask[k] && cm_req.data[k*128+:128] !== {88'h0, cm_req.addr + 40'(k * 16)})
          nb++;
      end
      if (hs && cm_req.write) begin
        pieces <= pieces + 1;
        wbad <= wbad + nb;
        coh <= cm_req.route == io_bridge_pkg::ROUTE_L1_L2;
      end else if (hs) begin
        rd <= 1'b1;
        ra <= cm_req.addr;
      end
    end
  end
  // Device: random ready, response held one I/O period
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {mst_ready, mst_rsp_valid, mv} <= '0;
      {rc, mst_rsp_data, seen} <= '0;
    end else begin
      hold = (mv && !mst_valid) || rc != 4'h0;
      mst_ready <= 1'($urandom);
      mv <= mst_valid;
      if (mst_valid && mst_ready) seen <= mst_req;
      mst_rsp_valid <= hold;
      mst_rsp_data <= hold ? ~seen.addr : ~mst_rsp_data;
      rc <= (mv && !mst_valid) ? ratio - 4'h1 : rc - 4'(rc != 4'h0);
    end
  end
endmodule // cm_partner

// ===== verification/io_coherence_bridge_test.sv
// Self-checking random bench for the I/O coherence bridge
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module io_coherence_bridge_test;
  logic sys_clk, rst, io_req_valid, io_req_ready, io_wvalid, io_wready, io_rvalid, io_bvalid;
  logic cm_req_valid, cm_req_ready, cm_rvalid, cm_wack, cpu_req_valid, cpu_req_ready;
  logic cpu_rsp_valid, mst_valid, mst_ready, mst_rsp_valid;
  logic [3:0]   io_ratio, io_btag;
  logic [127:0] io_wdata;
  logic [255:0] cm_rdata;
  logic [31:0]  cpu_rsp_data, mst_rsp_data;
  io_bridge_pkg::io_req_s   io_req;
  io_bridge_pkg::io_rbeat_s io_rbeat;
  io_bridge_pkg::cm_req_s   cm_req;
  io_bridge_pkg::mst_req_s  cpu_req, mst_req, seen;
  int bad_count, comparisons, cycles, pieces, wbad;
  int ratios[6] = '{1, 2, 3, 4, 5, 10};
  io_coherence_bridge dut (.*);
  cm_partner far (.ratio(io_ratio), .*);
  // Clock and hang guard
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  function automatic int npieces(logic [39:0] a, logic [3:0] n);
    return int'(((a + 40'(n) * 16) >> 5) - (a >> 5)) + 1;
  endfunction
  // One I/O burst, beats paced on the I/O period after accept
  task automatic io_xfer(input logic w, input int at, input logic [39:0] a,
                         input logic [3:0] n, input logic rr);
    int           k;
    int           p0;
    logic [3:0]   t;
    logic [127:0] pd;
    t = 4'($urandom);
    p0 = pieces;
    pd = '1;
    io_req <= '{w, io_bridge_pkg::attr_e'(at), a, n, t, rr};
    io_req_valid <= 1'b1;
    while (io_req_ready !== 1'b0) step();
    io_req_valid <= 1'b0;
    for (k = 0; w && k <= n; k++) begin
      io_wvalid <= 1'b1;
      io_wdata <= {88'h0, a + 40'(k * 16)};
      repeat (io_ratio) step();
    end
    io_wvalid <= 1'b0;
    k = 0;
    while (!w && k <= n) begin
      if (io_rvalid === 1'b1 && io_rbeat.data !== pd) begin
        `CHK(io_rbeat.data, {88'h0, a + 40'(k * 16)})
        `CHK(io_rbeat.tag, t)
        `CHK(io_rbeat.last, k == n)
        pd = io_rbeat.data;
        k++;
      end
      step();
    end
    while (w && io_req_ready !== 1'b1) step();
    if (w) `CHK(io_bvalid, rr)
    if (w) `CHK(pieces - p0, npieces(a, n))
  endtask
  // One CPU access through the master port
  task automatic cpu_xfer(input logic w);
    io_bridge_pkg::mst_req_s q;
    q = '{w, $urandom, $urandom};
    cpu_req <= q;
    cpu_req_valid <= 1'b1;
    while (cpu_req_ready !== 1'b0) step();
    cpu_req_valid <= 1'b0;
    while (cpu_rsp_valid !== 1'b1) step();
    `CHK(seen, q)
    if (!w) `CHK(cpu_rsp_data, ~q.addr)
  endtask
  // Main sequence, one test per ratio strap
  initial begin
    {rst, io_req_valid, io_wvalid, cpu_req_valid} = 4'h8;
    {io_req, cpu_req, io_wdata} = '0;
    io_ratio = 4'h1;
    void'($urandom(92148));
    foreach (ratios[i]) begin
      rst = 1'b1;
      io_ratio = 4'(ratios[i]);
      repeat (4) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      // Let the strap settle so beat pacing matches the enable
      repeat (8) step();
      io_xfer(1'b1, 0, 40'h10, 4'hf, 1'b1);
      io_xfer(1'b0, 1, 40'h10, 4'hf, 1'b0);
      for (int at = 0; at < 4; at++) begin
        io_xfer(1'b1, at, {8'h0, $urandom} & ~40'hf, 4'($urandom), 1'($urandom));
        io_xfer(1'b0, at, {8'h0, $urandom} & ~40'hf, 4'($urandom), 1'b0);
      end
      cpu_xfer(1'b0);
      cpu_xfer(1'b1);
      `CHK(wbad, 0)
      $display("ratio %0d test done", ratios[i]);
    end
    close_out();
  end
endmodule // io_coherence_bridge_test
